// File: inc/ccs_params.svh
// Purpose: offsets, field positions, reset values and encodings for the execution slice
// Assumes: AXI4-Lite byte addresses, one 32-bit word per register
// Notes:   definitions only
`ifndef CCS_PARAMS_SVH
`define CCS_PARAMS_SVH

`define CCS_ADDR_W      8
`define CCS_OFF_INSTR   8'h00
`define CCS_OFF_STATUS  8'h04
`define CCS_OFF_ACC     8'h08
`define CCS_OFF_PC      8'h0c
`define CCS_OFF_STACK   8'h10
`define CCS_OFF_FSEL    8'h14
`define CCS_OFF_FDATA   8'h18

`define CCS_Z_BIT       2
`define CCS_PAGE_HI     6
`define CCS_PAGE_LO     5
`define CCS_BUSY_BIT    8
`define CCS_SKIP_BIT    9

`define CCS_RST_STATUS  8'h00
`define CCS_RST_PC      11'h000

`define CCS_OP4_SKIPZ   4'h6
`define CCS_OP4_CALL    4'h9
`define CCS_OP7_CLR_REG  7'h03
`define CCS_OP12_CLR_ACC 12'h040

`define CCS_RESP_OKAY   2'h0
`define CCS_RESP_SLVERR 2'h2

`endif

// File: inc/ccs_pkg.sv
// Purpose: shared types of the execution slice
// Assumes: constants live in ccs_params.svh
// Notes:   none
package ccs_pkg;

  typedef enum logic [2:0] {
    OP_NOP,
    OP_SKIPZ,
    OP_CALL,
    OP_CLR_REG,
    OP_CLR_ACC
  } op_e;

  typedef enum logic [1:0] {
    EX_IDLE,
    EX_SKIP2,
    EX_CALL2
  } exec_e;

endpackage

// File: inc/dec_if.sv
// Purpose: carries one instruction word to the decoder and its fields back
// Assumes: purely combinational path
// Notes:   none
interface dec_if;
  logic [11:0]      word;
  ccs_pkg::op_e     op;
  logic [4:0]       freg;
  logic [2:0]       bsel;
  logic [7:0]       lit;

  modport core (output word, input op, input freg, input bsel, input lit);
  modport dec  (input word, output op, output freg, output bsel, output lit);
endinterface

// File: src/insn_decoder.sv
// Purpose: splits a 12-bit instruction word into class and operand fields
// Assumes: word is stable while the core samples the outputs
// Notes:   unknown encodings decode as a no-operation
`include "ccs_params.svh"

module insn_decoder (
  input  wire logic aclk,
  input  wire logic aresetn,
  dec_if.dec        d
);

  // fields sit at fixed positions whatever the opcode
  assign d.freg = d.word[4:0];
  assign d.bsel = d.word[7:5];
  assign d.lit  = d.word[7:0];

  always_comb begin
    if (d.word == `CCS_OP12_CLR_ACC) begin
      d.op = ccs_pkg::OP_CLR_ACC;
    end else if (d.word[11:5] == `CCS_OP7_CLR_REG) begin
      d.op = ccs_pkg::OP_CLR_REG;
    end else if (d.word[11:8] == `CCS_OP4_SKIPZ) begin
      d.op = ccs_pkg::OP_SKIPZ;
    end else if (d.word[11:8] == `CCS_OP4_CALL) begin
      d.op = ccs_pkg::OP_CALL;
    end else begin
      d.op = ccs_pkg::OP_NOP;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_fields;
    // checked from the word's side, so a call word decoded as any other class trips it
    (d.word[11:8] == `CCS_OP4_CALL) |-> (d.op == ccs_pkg::OP_CALL && d.lit == d.word[7:0]);
  endproperty
  a_fields: assert property (p_fields) else $error("call literal field misplaced");

endmodule

// File: src/call_clear_skip_execution.sv
// Purpose: executes skip-if-zero, subroutine call, clear register and clear accumulator
// Assumes: software issues instruction words through the INSTR register over AXI4-Lite
// Notes:   one write and one read under way at a time; INSTR writes while busy get SLVERR
//
// Chosen here: the register addresses and the AXI4-Lite interface to the registers.
`include "ccs_params.svh"

module call_clear_skip_execution (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  awaddr,
  input  wire logic [2:0]  awprot,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic [2:0]  arprot,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  output logic             busy
);

  typedef struct packed {
    logic              aw_got;
    logic [7:0]        aw_addr;
    logic              w_got;
    logic [31:0]       w_data;
    logic [3:0]        w_strb;
    logic              awready;
    logic              wready;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              arready;
    logic              rvalid;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
    ccs_pkg::exec_e    state;
    logic [11:0]       instr;
    logic [7:0]        status;
    logic [7:0]        acc;
    logic [10:0]       pc;
    logic [10:0]       stack_top;
    logic [4:0]        fsel;
    logic [31:0][7:0]  regs;
    logic              busy;
  } core_s;

  core_s s_ff;
  core_s nxt_s;
  logic  fire;

  dec_if dbus ();

  insn_decoder u_dec (
    .aclk    (aclk),
    .aresetn (aresetn),
    .d       (dbus)
  );

  // decode the word waiting in the write buffer, so execution lands on the commit edge
  assign dbus.word = s_ff.w_data[11:0];

  always_comb begin
    nxt_s = s_ff;
    fire  = 1'h0;
    if (awvalid && s_ff.awready) begin
      nxt_s.aw_got  = 1'h1;
      nxt_s.aw_addr = awaddr;
    end
    if (wvalid && s_ff.wready) begin
      nxt_s.w_got  = 1'h1;
      nxt_s.w_data = wdata;
      nxt_s.w_strb = wstrb;
    end
    if (s_ff.bvalid && bready) begin
      nxt_s.bvalid = 1'h0;
    end
    // the discarded instruction slot and the call's second cycle
    case (s_ff.state)
      ccs_pkg::EX_SKIP2: begin
        nxt_s.pc    = s_ff.pc + 11'h001;
        nxt_s.state = ccs_pkg::EX_IDLE;
      end
      ccs_pkg::EX_CALL2: begin
        nxt_s.state = ccs_pkg::EX_IDLE;
      end
      default: begin
        nxt_s.state = ccs_pkg::EX_IDLE;
      end
    endcase
    if (s_ff.aw_got && s_ff.w_got && !s_ff.bvalid) begin
      nxt_s.aw_got = 1'h0;
      nxt_s.w_got  = 1'h0;
      nxt_s.bvalid = 1'h1;
      nxt_s.bresp  = `CCS_RESP_OKAY;
      // only lane 0 enables a write; upper-lane strobes are ignored, though INSTR and PC take their top bits from lane 1
      case (s_ff.aw_addr)
        `CCS_OFF_INSTR: begin
          if (s_ff.state != ccs_pkg::EX_IDLE) begin
            nxt_s.bresp = `CCS_RESP_SLVERR;
          end else if (s_ff.w_strb[0]) begin
            fire        = 1'h1;
            nxt_s.instr = s_ff.w_data[11:0];
            nxt_s.pc    = s_ff.pc + 11'h001;
            case (dbus.op)
              ccs_pkg::OP_SKIPZ: begin
                if (!s_ff.regs[dbus.freg][dbus.bsel]) begin
                  nxt_s.state = ccs_pkg::EX_SKIP2;
                end
              end
              ccs_pkg::OP_CALL: begin
                nxt_s.stack_top = s_ff.pc + 11'h001;
                nxt_s.pc = {s_ff.status[`CCS_PAGE_HI:`CCS_PAGE_LO], 1'h0, dbus.lit};
                nxt_s.state = ccs_pkg::EX_CALL2;
              end
              ccs_pkg::OP_CLR_REG: begin
                nxt_s.regs[dbus.freg]      = 8'h00;
                nxt_s.status[`CCS_Z_BIT]   = 1'h1;
              end
              ccs_pkg::OP_CLR_ACC: begin
                nxt_s.acc                  = 8'h00;
                nxt_s.status[`CCS_Z_BIT]   = 1'h1;
              end
              default: begin
              end
            endcase
          end
        end
        `CCS_OFF_STATUS: begin
          if (s_ff.w_strb[0]) begin
            nxt_s.status = s_ff.w_data[7:0];
          end
        end
        `CCS_OFF_ACC: begin
          if (s_ff.w_strb[0]) begin
            nxt_s.acc = s_ff.w_data[7:0];
          end
        end
        `CCS_OFF_PC: begin
          if (s_ff.w_strb[0] && s_ff.state == ccs_pkg::EX_IDLE) begin
            nxt_s.pc = s_ff.w_data[10:0];
          end
        end
        `CCS_OFF_STACK: begin
        end
        `CCS_OFF_FSEL: begin
          if (s_ff.w_strb[0]) begin
            nxt_s.fsel = s_ff.w_data[4:0];
          end
        end
        `CCS_OFF_FDATA: begin
          if (s_ff.w_strb[0]) begin
            nxt_s.regs[s_ff.fsel] = s_ff.w_data[7:0];
          end
        end
        default: begin
          nxt_s.bresp = `CCS_RESP_SLVERR;
        end
      endcase
    end
    if (s_ff.rvalid && rready) begin
      nxt_s.rvalid = 1'h0;
    end
    if (arvalid && s_ff.arready) begin
      nxt_s.rvalid = 1'h1;
      nxt_s.rresp  = `CCS_RESP_OKAY;
      case (araddr)
        `CCS_OFF_INSTR:  nxt_s.rdata = {20'h00000, s_ff.instr};
        `CCS_OFF_STATUS: nxt_s.rdata = {22'h000000, s_ff.state == ccs_pkg::EX_SKIP2,
                                        s_ff.busy, s_ff.status};
        `CCS_OFF_ACC:    nxt_s.rdata = {24'h000000, s_ff.acc};
        `CCS_OFF_PC:     nxt_s.rdata = {21'h000000, s_ff.pc};
        `CCS_OFF_STACK:  nxt_s.rdata = {21'h000000, s_ff.stack_top};
        `CCS_OFF_FSEL:   nxt_s.rdata = {27'h0000000, s_ff.fsel};
        `CCS_OFF_FDATA:  nxt_s.rdata = {24'h000000, s_ff.regs[s_ff.fsel]};
        default: begin
          nxt_s.rdata = 32'h00000000;
          nxt_s.rresp = `CCS_RESP_SLVERR;
        end
      endcase
    end
    // readies come from the next state so every output stays a flop
    nxt_s.awready = !nxt_s.aw_got && !nxt_s.bvalid;
    nxt_s.wready  = !nxt_s.w_got && !nxt_s.bvalid;
    nxt_s.arready = !nxt_s.rvalid;
    nxt_s.busy    = nxt_s.state != ccs_pkg::EX_IDLE;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_ff        <= '0;
      s_ff.state  <= ccs_pkg::EX_IDLE;
      s_ff.status <= `CCS_RST_STATUS;
      s_ff.pc     <= `CCS_RST_PC;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign awready = s_ff.awready;
  assign wready  = s_ff.wready;
  assign bvalid  = s_ff.bvalid;
  assign bresp   = s_ff.bresp;
  assign arready = s_ff.arready;
  assign rvalid  = s_ff.rvalid;
  assign rdata   = s_ff.rdata;
  assign rresp   = s_ff.rresp;
  assign busy    = s_ff.busy;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_skip_taken;
    fire && dbus.op == ccs_pkg::OP_SKIPZ && !s_ff.regs[dbus.freg][dbus.bsel]
      |=> s_ff.busy ##1 (!s_ff.busy && s_ff.pc == $past(s_ff.pc, 2) + 11'h002);
  endproperty
  a_skip_taken: assert property (p_skip_taken) else $error("taken skip not two cycles");

  property p_skip_not;
    fire && dbus.op == ccs_pkg::OP_SKIPZ && s_ff.regs[dbus.freg][dbus.bsel]
      |=> !s_ff.busy && s_ff.pc == $past(s_ff.pc) + 11'h001;
  endproperty
  a_skip_not: assert property (p_skip_not) else $error("untaken skip not one cycle");

  property p_call_push;
    fire && dbus.op == ccs_pkg::OP_CALL |=> s_ff.stack_top == $past(s_ff.pc) + 11'h001;
  endproperty
  a_call_push: assert property (p_call_push) else $error("wrong return address");

  property p_call_low;
    fire && dbus.op == ccs_pkg::OP_CALL |=> s_ff.pc[7:0] == $past(s_ff.w_data[7:0]);
  endproperty
  a_call_low: assert property (p_call_low) else $error("call literal not loaded");

  property p_call_page;
    fire && dbus.op == ccs_pkg::OP_CALL
      |=> s_ff.pc[10:9] == $past(s_ff.status[6:5]) && !s_ff.pc[8];
  endproperty
  a_call_page: assert property (p_call_page) else $error("call page bits wrong");

  property p_call_two;
    fire && dbus.op == ccs_pkg::OP_CALL
      |=> (s_ff.busy && s_ff.status == $past(s_ff.status)) ##1 !s_ff.busy;
  endproperty
  a_call_two: assert property (p_call_two) else $error("call timing or flags wrong");

  property p_clr_reg;
    fire && dbus.op == ccs_pkg::OP_CLR_REG
      |=> s_ff.regs[$past(dbus.freg)] == 8'h00 && s_ff.status[2] && !s_ff.busy;
  endproperty
  a_clr_reg: assert property (p_clr_reg) else $error("register clear failed");

  property p_clr_acc;
    fire && dbus.op == ccs_pkg::OP_CLR_ACC
      |=> s_ff.acc == 8'h00 && s_ff.status[2] && !s_ff.busy;
  endproperty
  a_clr_acc: assert property (p_clr_acc) else $error("accumulator clear failed");

  c_skip: cover property (fire && dbus.op == ccs_pkg::OP_SKIPZ ##1 s_ff.busy);
  c_call: cover property (fire && dbus.op == ccs_pkg::OP_CALL);
  c_clr_reg: cover property (fire && dbus.op == ccs_pkg::OP_CLR_REG);
  c_clr_acc: cover property (fire && dbus.op == ccs_pkg::OP_CLR_ACC);

endmodule

// File: verif/prog_mem.sv
// Purpose: program memory model holding the instruction words that the bench issues
// Assumes: combinational read, word valid while addr is stable
// Notes:   unused addresses read as a no-operation word
module prog_mem (
  input  wire logic [2:0]  addr,
  output logic      [11:0] word
);
  timeunit 1ns;
  timeprecision 1ns;

  always_comb begin
    case (addr)
      3'h0:    word = 12'h643; // bit 2 of reg 3 is set: no skip
      3'h1:    word = 12'h603; // bit 0 of reg 3 is clear: skip
      3'h2:    word = 12'h9a5; // call, literal a5
      3'h3:    word = 12'h063; // clear reg 3
      3'h4:    word = 12'h040; // clear accumulator
      default: word = 12'h000;
    endcase
  end
endmodule

// File: verif/tb.sv
// Purpose: self-checking bench for the execution slice over its register bus
// Assumes: write answer after both handshakes, read answer one edge after address
// Notes:   waits are bounded; a hang counts as a mismatch
`include "ccs_params.svh"

module tb;
  timeunit 1ns;
  timeprecision 1ns;

  localparam logic [1:0] ok  = `CCS_RESP_OKAY;
  localparam logic [1:0] err = `CCS_RESP_SLVERR;

  logic        aclk, aresetn;
  logic [7:0]  awaddr, araddr;
  logic [2:0]  awprot, arprot, pa;
  logic        awvalid, wvalid, bready, arvalid, rready;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic        awready, wready, bvalid, arready, rvalid, busy;
  logic [1:0]  bresp, rresp;
  logic [11:0] pw;
  int          errors, num_checks, busy_cnt;

  call_clear_skip_execution i_call_clear_skip_execution (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(awprot),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arprot(arprot), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .busy(busy)
  );

  prog_mem i_prog_mem (.addr(pa), .word(pw));

  initial aclk = 1'b0;
  always #25 aclk = ~aclk;

  // busy is a one-cycle level, so it is counted every cycle
  always @(negedge aclk) begin
    if (busy === 1'b1) busy_cnt++;
  end

  task automatic complete_run;
    if (errors == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      $display("unexpected %s: expected %h seen %h", n, e, g);
      errors++;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int         i;
    logic       ta, tw, tg;
    logic [1:0] r;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    // outputs read mid-cycle: there they hold what the next rising edge sees
    for (i = 0; i < 50; i++) begin
      @(negedge aclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tg = bvalid === 1'b1;
      r  = bresp;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tg) break;
    end
    bready <= 1'b0;
    if (i == 50) begin
      errors++;
      complete_run();
    end
    chk("bresp", {30'h0, er}, {30'h0, r});
  endtask

  task automatic rd(input string n, input logic [7:0] a, input logic [31:0] e,
                    input logic [1:0] er);
    int          i;
    logic        ta, tg;
    logic [31:0] d;
    logic [1:0]  r;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(negedge aclk);
      ta = arvalid && arready;
      tg = rvalid === 1'b1;
      d  = rdata;
      r  = rresp;
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
      if (tg) break;
    end
    rready <= 1'b0;
    if (i == 50) begin
      errors++;
      complete_run();
    end
    chk(n, e, d);
    chk("rresp", {30'h0, er}, {30'h0, r});
  endtask

  // word comes from program memory; #1 lets the address settle off the edge
  task automatic exec(input logic [2:0] i);
    pa = i;
    #1;
    wr(`CCS_OFF_INSTR, {20'h0, pw}, ok);
  endtask

  initial begin
    aresetn = 1'b0;
    awaddr = 8'h00;
    araddr = 8'h00;
    awprot = 3'h0;
    arprot = 3'h0;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    wdata = 32'h0;
    wstrb = 4'hf;
    pa = 3'h0;
    errors = 0;
    num_checks = 0;
    busy_cnt = 0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    rd("pc_reset", `CCS_OFF_PC, 32'h0, ok);
    rd("status_reset", `CCS_OFF_STATUS, 32'h0, ok);
    wr(`CCS_OFF_FSEL, 32'h3, ok);
    wr(`CCS_OFF_FDATA, 32'h4, ok);
    exec(3'h0);
    rd("pc_no_skip", `CCS_OFF_PC, 32'h1, ok);
    exec(3'h1);
    rd("pc_skip", `CCS_OFF_PC, 32'h3, ok);
    wr(`CCS_OFF_STATUS, 32'h60, ok);
    exec(3'h2);
    rd("stack_top", `CCS_OFF_STACK, 32'h4, ok);
    rd("pc_call", `CCS_OFF_PC, 32'h6a5, ok);
    rd("status_call", `CCS_OFF_STATUS, 32'h60, ok);
    wr(`CCS_OFF_FDATA, 32'h5a, ok);
    exec(3'h3);
    rd("fdata_clear", `CCS_OFF_FDATA, 32'h0, ok);
    rd("status_clear_reg", `CCS_OFF_STATUS, 32'h64, ok);
    wr(`CCS_OFF_STATUS, 32'h0, ok);
    wr(`CCS_OFF_ACC, 32'h5a, ok);
    exec(3'h4);
    rd("acc_clear", `CCS_OFF_ACC, 32'h0, ok);
    rd("status_clear_acc", `CCS_OFF_STATUS, 32'h4, ok);
    rd("instr_last", `CCS_OFF_INSTR, 32'h40, ok);
    wstrb <= 4'he;
    wr(`CCS_OFF_ACC, 32'h33, ok);
    wstrb <= 4'hf;
    rd("acc_lane_off", `CCS_OFF_ACC, 32'h0, ok);
    wr(`CCS_OFF_PC, 32'h7ff, ok);
    exec(3'h5);
    rd("pc_wrap", `CCS_OFF_PC, 32'h0, ok);
    rd("unmapped", 8'h1c, 32'h0, err);
    wr(8'h1c, 32'h1, err);
    repeat (2) @(posedge aclk);
    chk("busy_cycles", 32'd2, busy_cnt);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd("stack_rerun", `CCS_OFF_STACK, 32'h0, ok);
    rd("status_rerun", `CCS_OFF_STATUS, 32'h0, ok);
    complete_run();
  end
endmodule
